// file: common/pmc_fef_if.sv
`timescale 1ns/10ps
interface pmc_fef_if;
    logic gen_en;    // Send fault pattern
    logic mac_bit;   // Normal transmit bit
    logic line_bit;  // Received line bit
    logic tx_bit;    // Transmit line bit
    logic fef_det;   // Fault pattern received
    modport gen (input gen_en, mac_bit, line_bit, output tx_bit, fef_det);
    modport ctl (output gen_en, mac_bit, line_bit, input tx_bit, fef_det);
endinterface

// file: common/pmc_pkg.sv
package pmc_pkg;
    // Far-end fault generator phase
    typedef enum logic [0:0] {
        PMC_FG_ONES = 1'b0,
        PMC_FG_ZERO = 1'b1
    } pmc_fg_state_t;
endpackage

// file: common/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Register indices and byte addresses (index times four)
`define PMC_IDX_CTRL      8'h00
`define PMC_IDX_STATUS    8'h01
`define PMC_IDX_PHYCTL    8'h1F
`define PMC_ADDR_CTRL     8'h00
`define PMC_ADDR_STATUS   8'h04
`define PMC_ADDR_PHYCTL   8'h7C
// Control register fields
`define PMC_CTRL_TXDIS    0
`define PMC_CTRL_PD       11
`define PMC_CTRL_ANEG     12
`define PMC_CTRL_RST      16'h1000
// Vendor control fields
`define PMC_PHY_PSDIS     10
`define PMC_PHY_MDIX      13
`define PMC_PHY_RST       16'h2000
// Status layout: fiber, signal, fault, link, pd, psave, rmii, b2b
`define PMC_STAT_W        8
// Pin synchroniser reset value, power-down pin idles high
`define PMC_SYNC_RST      8'h04
// Far-end fault pattern length in ones
`define PMC_FEF_ONES      7'h54
`endif

// file: logic/pmc_fef.sv
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_fef (
    input  wire logic clk,     // System clock
    input  wire logic arst_n,  // Async reset
    pmc_fef_if.gen    fif      // Fault generator link
);
    pmc_pkg::pmc_fg_state_t state;
    pmc_pkg::pmc_fg_state_t next_state;
    logic [6:0] gen_cnt;
    logic [6:0] next_gen_cnt;
    logic [6:0] ones_cnt;
    logic [6:0] next_ones_cnt;
    logic       tx_bit;
    logic       next_tx_bit;
    logic       det;
    logic       next_det;

    // Pattern generator and fault detector next values
    always_comb begin
        next_state    = state;
        next_gen_cnt  = gen_cnt;
        next_tx_bit   = fif.mac_bit;
        next_ones_cnt = ones_cnt;
        next_det      = det;
        if (fif.gen_en) begin
            case (state)
                pmc_pkg::PMC_FG_ONES: begin
                    next_tx_bit  = 1'b1;
                    next_gen_cnt = gen_cnt + 7'h01;
                    if (gen_cnt == `PMC_FEF_ONES - 7'h01) begin
                        next_state = pmc_pkg::PMC_FG_ZERO;
                    end
                end
                pmc_pkg::PMC_FG_ZERO: begin
                    next_tx_bit  = 1'b0;
                    next_gen_cnt = 7'h00;
                    next_state   = pmc_pkg::PMC_FG_ONES;
                end
                default: next_state = pmc_pkg::PMC_FG_ONES;
            endcase
        end else begin
            next_state   = pmc_pkg::PMC_FG_ONES;
            next_gen_cnt = 7'h00;
        end
        // A zero after a full run of ones marks a received fault
        if (fif.line_bit) begin
            if (ones_cnt != 7'h7F) begin
                next_ones_cnt = ones_cnt + 7'h01;
            end
        end else begin
            next_det      = (ones_cnt == `PMC_FEF_ONES);
            next_ones_cnt = 7'h00;
        end
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= pmc_pkg::PMC_FG_ONES;
            gen_cnt  <= 7'h00;
            ones_cnt <= 7'h00;
            tx_bit   <= 1'b0;
            det      <= 1'b0;
        end else begin
            state    <= next_state;
            gen_cnt  <= next_gen_cnt;
            ones_cnt <= next_ones_cnt;
            tx_bit   <= next_tx_bit;
            det      <= next_det;
        end
    end

    assign fif.tx_bit  = tx_bit;
    assign fif.fef_det = det;

    fef_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        fif.gen_en && state == pmc_pkg::PMC_FG_ZERO |=> !tx_bit && $past(tx_bit))
        else $error("fault pattern zero not sent after ones");
    fef_run_a: assert property (@(posedge clk) disable iff (!arst_n)
        fif.gen_en && state == pmc_pkg::PMC_FG_ONES |=> tx_bit && gen_cnt <= `PMC_FEF_ONES)
        else $error("fault pattern run of ones broken");
    fef_pass_a: assert property (@(posedge clk) disable iff (!arst_n)
        !fif.gen_en |=> tx_bit == $past(fif.mac_bit))
        else $error("transmit path altered outside fault generation");
endmodule // pmc_fef

// file: logic/pmc_top.sv
`timescale 1ns/10ps
`include "pmc_regs.svh"
module pmc_top (
    input  wire logic        clk,                          // 10 MHz clock
    input  wire logic        arst_n,                       // Async reset
    input  wire logic [7:0]  avs_address,                  // Byte address
    input  wire logic        avs_read,                     // Read request
    input  wire logic        avs_write,                    // Write request
    input  wire logic [31:0] avs_writedata,                // Write data
    output logic      [31:0] avs_readdata,                 // Read data
    output logic             avs_waitrequest,              // Wait request
    input  wire logic        rmii_mode_strap,              // Pin: reduced mode
    input  wire logic        fef_enable_strap,             // Pin: fault enable
    input  wire logic        back_to_back_strap,           // Pin: converter
    input  wire logic        power_down_pin_n,             // Pin: power down
    input  wire logic [1:0]  fiber_signal_detect_in,       // Pin: thresholds
    input  wire logic        converter_tx_disable_in,      // Pin: tx disable
    input  wire logic        line_energy_in,               // Pin: energy seen
    input  wire logic        copper_link_in,               // Copper link good
    input  wire logic        crs_dv_in,                    // Frame in progress
    input  wire logic        rx_code_err_in,               // Decode error
    input  wire logic        mac_tx_bit_in,                // MAC transmit bit
    input  wire logic        rx_line_bit_in,               // Received line bit
    output logic             rx_er,                        // Receive error
    output logic             tx_line_bit,                  // Line transmit bit
    output logic             tx_line_oe,                   // Line driver on
    output logic             rmii_mode,                    // Reduced mode
    output logic             fiber_mode,                   // Fiber selected
    output logic             far_end_fault,                // Fault received
    output logic             link_up,                      // Link reported up
    output logic             auto_neg_en,                  // Negotiation on
    output logic             auto_mdix_en,                 // Crossover on
    output logic             deny_10m,                     // No 10 Mb/s link
    output logic             power_down,                   // Powered down
    output logic             power_save_active,            // Circuits shut
    output logic             converter_energy_detect_out   // Spare rx bit
);
    pmc_fef_if fif ();

    // Pin synchronisers: s1 feeds only s2
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic       sd_mode_s;
    logic       sd_sig_s;
    logic       pd_n_s;
    logic       txdis_s;
    logic       energy_s;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1 <= `PMC_SYNC_RST;
            pin_s2 <= `PMC_SYNC_RST;
        end else begin
            pin_s1 <= {back_to_back_strap, fef_enable_strap, rmii_mode_strap,
                       energy_in_w(line_energy_in), converter_tx_disable_in,
                       power_down_pin_n, fiber_signal_detect_in};
            pin_s2 <= pin_s1;
        end
    end

    function automatic logic energy_in_w(input logic e);
        energy_in_w = e;
    endfunction

    assign sd_mode_s = pin_s2[0];
    assign sd_sig_s  = pin_s2[1];
    assign pd_n_s    = pin_s2[2];
    assign txdis_s   = pin_s2[3];
    assign energy_s  = pin_s2[4];

    // Strap capture once the synchroniser has filled after reset
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic [2:0] straps;
    logic [2:0] next_straps;

    always_comb begin
        next_strap_cnt = strap_cnt;
        next_straps    = straps;
        if (strap_cnt != 2'h3) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == 2'h2) begin
                next_straps = pin_s2[7:5];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt <= 2'h0;
            straps    <= 3'h0;
        end else begin
            strap_cnt <= next_strap_cnt;
            straps    <= next_straps;
        end
    end

    logic rmii_st;
    logic fef_st;
    logic b2b_st;
    assign rmii_st = straps[0];
    assign fef_st  = straps[1];
    assign b2b_st  = straps[2];

    // Avalon slave: one wait cycle, then a single accept cycle
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] phyctl;
    logic [15:0] next_phyctl;
    logic [31:0] next_readdata;
    logic        next_waitrequest;
    logic        req;
    logic        acc_wr;
    logic [7:0]  status;

    assign req    = avs_read || avs_write;
    assign acc_wr = avs_write && !avs_waitrequest;
    assign status = {b2b_st, rmii_st, power_save_active, power_down,
                     link_up, far_end_fault, sd_sig_s && fiber_mode, fiber_mode};

    always_comb begin
        next_ctrl        = ctrl;
        next_phyctl      = phyctl;
        next_readdata    = avs_readdata;
        next_waitrequest = !(req && avs_waitrequest);
        if (req && avs_waitrequest) begin
            if (avs_address == `PMC_ADDR_CTRL) begin
                next_readdata = {16'h0000, ctrl};
            end else if (avs_address == `PMC_ADDR_STATUS) begin
                next_readdata = {24'h000000, status};
            end else if (avs_address == `PMC_ADDR_PHYCTL) begin
                next_readdata = {16'h0000, phyctl};
            end else begin
                next_readdata = 32'h00000000;
            end
        end
        if (acc_wr) begin
            if (avs_address == `PMC_ADDR_CTRL) begin
                next_ctrl = avs_writedata[15:0];
            end else if (avs_address == `PMC_ADDR_PHYCTL) begin
                next_phyctl = avs_writedata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl            <= `PMC_CTRL_RST;
            phyctl          <= `PMC_PHY_RST;
            avs_readdata    <= 32'h00000000;
            avs_waitrequest <= 1'b1;
        end else begin
            ctrl            <= next_ctrl;
            phyctl          <= next_phyctl;
            avs_readdata    <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    // Mode and link logic feeding the registered outputs
    logic next_rx_er;
    logic next_tx_line_oe;
    logic next_rmii_mode;
    logic next_fiber_mode;
    logic next_far_end_fault;
    logic next_link_up;
    logic next_auto_neg_en;
    logic next_auto_mdix_en;
    logic next_deny_10m;
    logic next_power_down;
    logic next_power_save;
    logic next_energy_out;
    logic conv;

    // Converter use needs both the reduced-pin and back-to-back straps
    assign conv = rmii_st && b2b_st;

    always_comb begin
        // Error only while a frame is passed; the MAC drops it otherwise
        next_rx_er        = crs_dv_in && rx_code_err_in;
        next_rmii_mode    = rmii_st;
        next_fiber_mode   = sd_mode_s;
        next_far_end_fault = next_fiber_mode && fif.fef_det;
        if (next_fiber_mode) begin
            next_link_up = sd_sig_s && !fif.fef_det;
        end else begin
            next_link_up = copper_link_in;
        end
        next_auto_neg_en  = !next_fiber_mode && ctrl[`PMC_CTRL_ANEG];
        next_auto_mdix_en = !next_fiber_mode && phyctl[`PMC_PHY_MDIX];
        next_deny_10m     = conv && !next_fiber_mode;
        next_power_down   = ctrl[`PMC_CTRL_PD] || !pd_n_s;
        next_power_save   = !phyctl[`PMC_PHY_PSDIS] && !next_link_up
                            && !next_power_down;
        next_tx_line_oe   = !(conv && txdis_s) && !next_power_down
                            && !next_power_save
                            && !ctrl[`PMC_CTRL_TXDIS];
        next_energy_out   = conv && !next_fiber_mode && energy_s;
    end

    // Fault generator hookup
    assign fif.gen_en   = fiber_mode && !sd_sig_s && fef_st;
    assign fif.mac_bit  = mac_tx_bit_in;
    assign fif.line_bit = rx_line_bit_in;

    pmc_fef u_fef (
        .clk    (clk),
        .arst_n (arst_n),
        .fif    (fif)
    );

    // Output registers, all changing on the rising edge only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_er                       <= 1'b0;
            tx_line_bit                 <= 1'b0;
            tx_line_oe                  <= 1'b0;
            rmii_mode                   <= 1'b0;
            fiber_mode                  <= 1'b0;
            far_end_fault               <= 1'b0;
            link_up                     <= 1'b0;
            auto_neg_en                 <= 1'b0;
            auto_mdix_en                <= 1'b0;
            deny_10m                    <= 1'b0;
            power_down                  <= 1'b0;
            power_save_active           <= 1'b0;
            converter_energy_detect_out <= 1'b0;
        end else begin
            rx_er                       <= next_rx_er;
            tx_line_bit                 <= fif.tx_bit;
            tx_line_oe                  <= next_tx_line_oe;
            rmii_mode                   <= next_rmii_mode;
            fiber_mode                  <= next_fiber_mode;
            far_end_fault               <= next_far_end_fault;
            link_up                     <= next_link_up;
            auto_neg_en                 <= next_auto_neg_en;
            auto_mdix_en                <= next_auto_mdix_en;
            deny_10m                    <= next_deny_10m;
            power_down                  <= next_power_down;
            power_save_active           <= next_power_save;
            converter_energy_detect_out <= next_energy_out;
        end
    end

    rxer_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        crs_dv_in && rx_code_err_in |=> rx_er)
        else $error("receive error missed a frame error");
    rxer_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        !(crs_dv_in && rx_code_err_in) |=> !rx_er)
        else $error("receive error high with no error");
    pd_enter_a: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl[`PMC_CTRL_PD] || !pd_n_s |=> power_down)
        else $error("power down not entered");
    fiber_force_a: assert property (@(posedge clk) disable iff (!arst_n)
        fiber_mode |-> !auto_neg_en && !auto_mdix_en)
        else $error("negotiation or crossover on in fiber mode");
    fault_link_a: assert property (@(posedge clk) disable iff (!arst_n)
        far_end_fault |-> !link_up)
        else $error("link up while far-end fault received");
    conv_txoff_a: assert property (@(posedge clk) disable iff (!arst_n)
        conv && txdis_s |=> !tx_line_oe)
        else $error("driver on while converter disable high");
    no_10m_a: assert property (@(posedge clk) disable iff (!arst_n)
        $past(conv) && !fiber_mode && $past(strap_cnt) == 2'h3 |-> deny_10m)
        else $error("10 Mb/s allowed on converter copper side");
    psave_link_a: assert property (@(posedge clk) disable iff (!arst_n)
        power_save_active |-> !link_up && !tx_line_oe)
        else $error("power save active with link or driver on");
    mdix_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        acc_wr && avs_address == `PMC_ADDR_PHYCTL
        && !avs_writedata[`PMC_PHY_MDIX] ##1 !acc_wr |=> !auto_mdix_en)
        else $error("crossover not disabled by write");
    bus_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
endmodule // pmc_top

// file: tb/pmc_mac_model.sv
`timescale 1ns/10ps
module pmc_mac_model (
    input  wire logic       clk,      // Shared clock
    input  wire logic       arst_n,   // Async reset
    input  wire logic       start,    // Begin a frame
    input  wire logic [7:0] err_at,   // Frame slot with a code error
    input  wire logic       idle_err, // Code error between frames
    input  wire logic       rx_er,    // Error seen from the PHY
    output logic            crs_dv,   // Frame in progress
    output logic            code_err, // Decode error to the PHY
    output logic            mac_bit,  // Transmit bit
    output logic      [7:0] err_seen  // Errors taken by the MAC
);
    logic [7:0] pos;
    logic [4:0] cnt;
    // Frame slot counter, transmit pattern and error tally
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos <= 8'h00;
            cnt <= 5'h00;
            err_seen <= 8'h00;
        end else begin
            cnt <= cnt + 5'h01;
            pos <= start ? 8'h01 : ((pos != 8'h00 && pos < 8'h08) ? pos + 8'h01 : 8'h00);
            if (rx_er && crs_dv) err_seen <= err_seen + 8'h01;
        end
    end
    // Frame eight slots long, errors placed on request
    assign crs_dv = pos != 8'h00;
    assign code_err = crs_dv ? (pos == err_at) : idle_err;
    assign mac_bit = cnt[0] ^ cnt[3];
endmodule // pmc_mac_model

// file: tb/testbench.sv
`timescale 1ns/10ps
`include "pmc_regs.svh"
module testbench;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address, err_at, err_seen;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic rmii_s, fef_s, b2b_s, pd_n, txdis, energy, clink, crs_dv, code_err, mac_bit, rx_line;
    logic [1:0] fsd;
    logic start, idle_err, rx_er, tx_line_bit, tx_line_oe, rmii_mode, fiber_mode, far_end_fault;
    logic link_up, auto_neg_en, auto_mdix_en, deny_10m, power_down, power_save_active, energy_out;
    int num_errors, tests_run;
    // Design and MAC partner
    pmc_top dut_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rmii_mode_strap(rmii_s), .fef_enable_strap(fef_s), .back_to_back_strap(b2b_s),
        .power_down_pin_n(pd_n), .fiber_signal_detect_in(fsd),
        .converter_tx_disable_in(txdis), .line_energy_in(energy), .copper_link_in(clink),
        .crs_dv_in(crs_dv), .rx_code_err_in(code_err), .mac_tx_bit_in(mac_bit),
        .rx_line_bit_in(rx_line), .rx_er(rx_er), .tx_line_bit(tx_line_bit),
        .tx_line_oe(tx_line_oe), .rmii_mode(rmii_mode), .fiber_mode(fiber_mode),
        .far_end_fault(far_end_fault), .link_up(link_up), .auto_neg_en(auto_neg_en),
        .auto_mdix_en(auto_mdix_en), .deny_10m(deny_10m), .power_down(power_down),
        .power_save_active(power_save_active), .converter_energy_detect_out(energy_out));
    pmc_mac_model mac_u (.clk(clk), .arst_n(arst_n), .start(start), .err_at(err_at),
        .idle_err(idle_err), .rx_er(rx_er), .crs_dv(crs_dv), .code_err(code_err),
        .mac_bit(mac_bit), .err_seen(err_seen));
    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Verdict and end of run
    task finish_test;
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Compare and report
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Pins reach the outputs within a few edges
    task settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    // Reset with the straps as currently set
    task do_reset;
        @(posedge clk) arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        settle;
    endtask
    // Line bit is the MAC bit of two cycles back: generator stage plus output stage
    task chk_follow;
        logic [1:0] last;
        @(negedge clk) last[0] = mac_bit;
        @(negedge clk) last = {last[0], mac_bit};
        repeat (20) begin
            @(negedge clk);
            chk("tx_line_bit", tx_line_bit, last[1]);
            last = {last[0], mac_bit};
        end
    endtask
    // One frame; count error pulses on the pin and at the MAC
    task rxer_frame(input logic [7:0] at, input int pulses, input logic [7:0] taken);
        int n;
        logic [7:0] base;
        base = err_seen;
        n = 0;
        @(posedge clk);
        start <= 1'b1;
        err_at <= at;
        @(posedge clk) start <= 1'b0;
        repeat (14) begin
            @(negedge clk);
            if (rx_er === 1'b1) n++;
        end
        chk("rx_er pulses", n, pulses);
        chk("errors taken", err_seen - base, taken);
    endtask
    // Received line: a zero, a run of ones, a zero, then ones
    task send_run(input int ones);
        @(posedge clk) rx_line <= 1'b0;
        repeat (ones) @(posedge clk) rx_line <= 1'b1;
        @(posedge clk) rx_line <= 1'b0;
        @(posedge clk) rx_line <= 1'b1;
        settle;
    endtask
    // Generated pattern: count two runs of ones between zeros
    task fef_runs;
        int n;
        n = 0;
        while (tx_line_bit !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        repeat (2) begin
            n = 0;
            @(negedge clk);
            while (tx_line_bit === 1'b1 && n < 300) begin
                n++;
                @(negedge clk);
            end
            chk("fault ones", n, 32'h54);
        end
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test;
    end
    // Main sequence
    initial begin
        {arst_n, avs_read, avs_write, rmii_s, b2b_s, txdis, energy, clink} = 8'h00;
        {start, idle_err, rx_line, avs_address, err_at, fsd, avs_writedata} = 53'h0;
        {fef_s, pd_n, num_errors, tests_run} = 66'h0;
        fef_s = 1'b1;
        pd_n = 1'b1;
        do_reset;
        chk("rmii_mode", rmii_mode, 1'b0);
        chk("fiber_mode", fiber_mode, 1'b0);
        chk("psave default", power_save_active, 1'b1);
        chk("oe in psave", tx_line_oe, 1'b0);
        chk("auto_mdix", auto_mdix_en, 1'b1);
        chk("auto_neg", auto_neg_en, 1'b1);
        bus(1'b0, `PMC_ADDR_CTRL, 32'h0);
        chk("ctrl", q, 32'h1000);
        bus(1'b0, `PMC_ADDR_PHYCTL, 32'h0);
        chk("vendor", q, 32'h2000);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b0, `PMC_ADDR_STATUS, 32'h0);
        chk("status", q, 32'h20);
        bus(1'b1, `PMC_ADDR_PHYCTL, 32'h0400);
        settle;
        chk("psave off", power_save_active, 1'b0);
        chk("auto_mdix off", auto_mdix_en, 1'b0);
        bus(1'b0, `PMC_ADDR_PHYCTL, 32'h0);
        chk("vendor write", q, 32'h0400);
        bus(1'b1, `PMC_ADDR_PHYCTL, 32'h2000);
        @(posedge clk) clink <= 1'b1;
        settle;
        chk("psave link", power_save_active, 1'b0);
        chk("oe link", tx_line_oe, 1'b1);
        bus(1'b1, `PMC_ADDR_CTRL, 32'h1800);
        settle;
        chk("pd reg", power_down, 1'b1);
        chk("oe pd", tx_line_oe, 1'b0);
        bus(1'b1, `PMC_ADDR_CTRL, 32'h1000);
        settle;
        chk("pd clear", power_down, 1'b0);
        @(posedge clk) pd_n <= 1'b0;
        settle;
        chk("pd pin", power_down, 1'b1);
        @(posedge clk) pd_n <= 1'b1;
        idle_err <= 1'b1;
        rxer_frame(8'h00, 0, 8'h00);
        @(posedge clk) idle_err <= 1'b0;
        rxer_frame(8'h03, 1, 8'h01);
        rxer_frame(8'h08, 1, 8'h00);
        @(posedge clk) fsd <= 2'b01;
        settle;
        chk("fiber", fiber_mode, 1'b1);
        chk("aneg forced", auto_neg_en, 1'b0);
        chk("mdix forced", auto_mdix_en, 1'b0);
        bus(1'b0, `PMC_ADDR_STATUS, 32'h0);
        chk("status fiber", q, 32'h21);
        fef_runs;
        @(posedge clk) fsd <= 2'b11;
        settle;
        chk("link signal", link_up, 1'b1);
        send_run(84);
        chk("fault seen", far_end_fault, 1'b1);
        chk("link fault", link_up, 1'b0);
        chk_follow;
        send_run(10);
        chk("fault clear", far_end_fault, 1'b0);
        @(posedge clk) fsd <= 2'b01;
        fef_s <= 1'b0;
        do_reset;
        chk_follow;
        @(posedge clk) {fef_s, rmii_s, b2b_s} <= 3'h7;
        fsd <= 2'b00;
        do_reset;
        chk("rmii strap", rmii_mode, 1'b1);
        chk("deny 10m", deny_10m, 1'b1);
        @(posedge clk) energy <= 1'b1;
        settle;
        chk("energy", energy_out, 1'b1);
        @(posedge clk) txdis <= 1'b1;
        settle;
        chk("oe conv copper", tx_line_oe, 1'b0);
        @(posedge clk) fsd <= 2'b11;
        energy <= 1'b0;
        settle;
        chk("energy low", energy_out, 1'b0);
        chk("oe conv fiber", tx_line_oe, 1'b0);
        chk("deny fiber", deny_10m, 1'b0);
        @(posedge clk) txdis <= 1'b0;
        settle;
        chk("oe conv on", tx_line_oe, 1'b1);
        finish_test;
    end
endmodule // testbench
